/* dbdc_top.sv */
// How it works
// - Bit 6 of the pin-to-DSP enable register passes general pin 2 to the DSP port bus, else blocks it; resets 0.
// - Bit 4 of the pin-to-DSP enable register passes general pin 0 to the DSP port bus, else withholds it; resets 0.
// - Boot-source bit 1 set boots the DSP from instruction RAM, clear (reset) boots from instruction ROM.
// - Coefficient-source bit 0 set selects default coefficients from coefficient ROM, clear selects downloaded ones.
// - Writing 1 to the host-to-DSP interrupt bit raises a request held until the DSP acknowledges; writing 0 does nothing.
// - With memory-read enable bit 3 clear (reset) reads of instruction RAM, instruction ROM and coefficient ROM give zero.
// - Downloaded instruction RAM content is decrypted while decryption-disable bit 2 is clear, stored raw when set.
// - The two-bit seed select picks the CRC seed: 00 A5h, 01 B6h, 10 94h, 11 E2h; resets 00.
// - Writing 1 to the decryption-reset bit resets the decryption block and reloads the selected seed, then self-clears.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module dbdc_top #(
    parameter int MEM_WIDTH = 32
) (
    input  wire logic                            sys_clk,
    input  wire logic                            reset_n,
    input  wire logic [dbdc_pkg::ADDR_WIDTH-1:0] regAddr,
    input  wire logic [dbdc_pkg::DATA_WIDTH-1:0] regWriteData,
    input  wire logic                            regWrite,
    input  wire logic                            regRead,
    output logic      [dbdc_pkg::DATA_WIDTH-1:0] regReadData,
    input  wire logic                            generalPin0,
    input  wire logic                            generalPin1,
    input  wire logic                            generalPin2,
    output logic      [2:0]                      dspInputPort,
    output logic                                 bootFromInstructionRam,
    output logic                                 useCoefficientRom,
    output logic                                 hostToDspInterrupt,
    input  wire logic                            dspInterruptAck,
    input  wire logic                            downloadValid,
    input  wire logic [7:0]                      downloadData,
    output logic                                 ramWriteValid,
    output logic      [7:0]                      ramWriteData,
    input  wire logic [MEM_WIDTH-1:0]            instructionRamData,
    input  wire logic [MEM_WIDTH-1:0]            instructionRomData,
    input  wire logic [MEM_WIDTH-1:0]            coefficientRomData,
    output logic      [MEM_WIDTH-1:0]            instructionRamRead,
    output logic      [MEM_WIDTH-1:0]            instructionRomRead,
    output logic      [MEM_WIDTH-1:0]            coefficientRomRead
);
    import dbdc_pkg::*;

    dbdc_bus_req_type busReq;
    dbdc_ctrl_type    ctrl;
    logic [7:0]       pinEnableReg;
    logic [7:0]       bootSelectReg;
    logic [7:0]       memControlReg;
    logic             interruptPending;
    logic             decryptReset;
    logic [7:0]       crcState;
    logic [7:0]       next_readData;

    assign busReq = '{addr: regAddr, wdata: regWriteData, write: regWrite, read: regRead};

    function automatic logic hit(input dbdc_bus_req_type r, input logic [7:0] offset);
        hit = r.write && (r.addr == offset);
    endfunction

    // Plain read/write control registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinEnableReg  <= RESET_PIN_TO_DSP_ENABLE;
            bootSelectReg <= RESET_DSP_BOOT_SELECT;
            memControlReg <= RESET_MEM_READ_DECRYPT;
        end else begin
            if (hit(busReq, OFFSET_PIN_TO_DSP_ENABLE)) begin
                pinEnableReg <= busReq.wdata & MASK_PIN_TO_DSP_ENABLE;
            end
            if (hit(busReq, OFFSET_DSP_BOOT_SELECT)) begin
                bootSelectReg <= busReq.wdata & MASK_DSP_BOOT_SELECT;
            end
            if (hit(busReq, OFFSET_MEM_READ_DECRYPT)) begin
                memControlReg <= busReq.wdata & MASK_MEM_READ_DECRYPT;
            end
        end
    end

    always_comb begin
        ctrl.pin2ToDspEnable        = pinEnableReg[POS_PIN2_TO_DSP_ENABLE];
        ctrl.pin0ToDspEnable        = pinEnableReg[POS_PIN0_TO_DSP_ENABLE];
        ctrl.pin1ToDspEnable        = pinEnableReg[POS_PIN1_TO_DSP_ENABLE];
        ctrl.bootFromRam            = bootSelectReg[POS_BOOT_SOURCE];
        ctrl.useDefaultCoefficients = bootSelectReg[POS_COEFFICIENT_SOURCE];
        ctrl.memoryReadEnable       = memControlReg[POS_MEMORY_READ_ENABLE];
        ctrl.decryptionDisable      = memControlReg[POS_DECRYPTION_DISABLE];
        ctrl.crcSeedSelect          = memControlReg[POS_CRC_SEED_SELECT +: 2];
    end

    // Host-to-DSP interrupt; a new write of 1 wins over an acknowledge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            interruptPending <= 1'b0;
        end else if (hit(busReq, OFFSET_DSP_INTERRUPT_REQ) && busReq.wdata[POS_HOST_TO_DSP_INT]) begin
            interruptPending <= 1'b1;
        end else if (dspInterruptAck) begin
            interruptPending <= 1'b0;
        end
    end

    // Self-clearing one-cycle decryption reset pulse
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            decryptReset <= 1'b0;
        end else begin
            decryptReset <= hit(busReq, OFFSET_DECRYPT_RESET) && busReq.wdata[POS_DECRYPTION_RESET];
        end
    end

    // Outputs toward the DSP, all from flip-flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dspInputPort           <= 3'h0;
            bootFromInstructionRam <= 1'b0;
            useCoefficientRom      <= 1'b0;
            hostToDspInterrupt     <= 1'b0;
        end else begin
            dspInputPort[2]        <= generalPin2 & ctrl.pin2ToDspEnable;
            dspInputPort[1]        <= generalPin1 & ctrl.pin1ToDspEnable;
            dspInputPort[0]        <= generalPin0 & ctrl.pin0ToDspEnable;
            bootFromInstructionRam <= ctrl.bootFromRam;
            useCoefficientRom      <= ctrl.useDefaultCoefficients;
            hostToDspInterrupt     <= interruptPending;
        end
    end

    // Register read mux
    always_comb begin
        next_readData = 8'h00;
        unique case (busReq.addr)
            OFFSET_PIN_TO_DSP_ENABLE: next_readData = pinEnableReg;
            OFFSET_DSP_BOOT_SELECT:   next_readData = bootSelectReg;
            OFFSET_DSP_INTERRUPT_REQ: next_readData = {7'h00, interruptPending};
            OFFSET_MEM_READ_DECRYPT:  next_readData = memControlReg;
            OFFSET_DECRYPT_RESET:     next_readData = 8'h00;
            default:                  next_readData = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            regReadData <= 8'h00;
        end else begin
            regReadData <= busReq.read ? next_readData : 8'h00;
        end
    end

    dbdc_decrypt u_decrypt (
        .sys_clk           (sys_clk),
        .reset_n           (reset_n),
        .decryptReset      (decryptReset),
        .crcSeedSelect     (ctrl.crcSeedSelect),
        .decryptionDisable (ctrl.decryptionDisable),
        .inValid           (downloadValid),
        .inData            (downloadData),
        .outValid          (ramWriteValid),
        .outData           (ramWriteData),
        .crcState          (crcState)
    );

    dbdc_mem_gate #(
        .WIDTH (MEM_WIDTH)
    ) u_mem_gate (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .readEnable   (ctrl.memoryReadEnable),
        .ramData      (instructionRamData),
        .romData      (instructionRomData),
        .coefRomData  (coefficientRomData),
        .ramGated     (instructionRamRead),
        .romGated     (instructionRomRead),
        .coefRomGated (coefficientRomRead)
    );

    // Checks
    property p_pin2_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        ##1 dspInputPort[2] == ($past(generalPin2) & $past(pinEnableReg[POS_PIN2_TO_DSP_ENABLE]));
    endproperty
    a_pin2_gate: assert property (p_pin2_gate) else $error("Pin 2 gate wrong");

    property p_pin0_gate;
        @(posedge sys_clk) disable iff (!reset_n)
        !pinEnableReg[POS_PIN0_TO_DSP_ENABLE] |=> !dspInputPort[0];
    endproperty
    a_pin0_gate: assert property (p_pin0_gate) else $error("Pin 0 not withheld");

    property p_boot_source;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(busReq, OFFSET_DSP_BOOT_SELECT) |=> ##1 bootFromInstructionRam == $past(busReq.wdata[POS_BOOT_SOURCE], 2);
    endproperty
    a_boot_source: assert property (p_boot_source) else $error("Boot source wrong");

    property p_coef_source;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(busReq, OFFSET_DSP_BOOT_SELECT) |=> ##1 useCoefficientRom == $past(busReq.wdata[0], 2);
    endproperty
    a_coef_source: assert property (p_coef_source) else $error("Coefficient source wrong");

    property p_int_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        interruptPending && !dspInterruptAck |=> interruptPending;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("Interrupt dropped before acknowledge");

    property p_int_set;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(busReq, OFFSET_DSP_INTERRUPT_REQ) && busReq.wdata[0] |=> interruptPending ##1 hostToDspInterrupt;
    endproperty
    a_int_set: assert property (p_int_set) else $error("Interrupt not raised");

    property p_read_block;
        @(posedge sys_clk) disable iff (!reset_n)
        !ctrl.memoryReadEnable |=> instructionRamRead == '0 && coefficientRomRead == '0;
    endproperty
    a_read_block: assert property (p_read_block) else $error("Memory read not blocked");

    property p_decrypt_on;
        @(posedge sys_clk) disable iff (!reset_n)
        downloadValid && !decryptReset && !ctrl.decryptionDisable
            |=> ramWriteValid && ramWriteData == ($past(downloadData) ^ $past(crcState));
    endproperty
    a_decrypt_on: assert property (p_decrypt_on) else $error("Download not decrypted");

    property p_seed;
        @(posedge sys_clk) disable iff (!reset_n)
        decryptReset |=> crcState == seed_of($past(ctrl.crcSeedSelect));
    endproperty
    a_seed: assert property (p_seed) else $error("Wrong seed loaded");

    property p_reset_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(busReq, OFFSET_DECRYPT_RESET) && busReq.wdata[0] |=> decryptReset ##1 !decryptReset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("Decrypt reset not one cycle");

    property p_crc_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        !decryptReset && !(downloadValid && !ctrl.decryptionDisable) |=> $stable(crcState);
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("CRC state moved");

    property p_raw;
        @(posedge sys_clk) disable iff (!reset_n)
        downloadValid && !decryptReset && ctrl.decryptionDisable
            |=> ramWriteValid && ramWriteData == $past(downloadData);
    endproperty
    a_raw: assert property (p_raw) else $error("Raw byte altered");

    property p_pin0_pass;
        @(posedge sys_clk) disable iff (!reset_n)
        generalPin0 && ctrl.pin0ToDspEnable |=> dspInputPort[0];
    endproperty
    a_pin0_pass: assert property (p_pin0_pass) else $error("Pin 0 not passed");

    property p_boot_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        !hit(busReq, OFFSET_DSP_BOOT_SELECT) |=> ##1 $stable(bootFromInstructionRam);
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("Boot source moved");

    property p_int_ignore;
        @(posedge sys_clk) disable iff (!reset_n)
        hit(busReq, OFFSET_DSP_INTERRUPT_REQ) && !busReq.wdata[POS_HOST_TO_DSP_INT]
            && !interruptPending |=> !interruptPending;
    endproperty
    a_int_ignore: assert property (p_int_ignore) else $error("Write of 0 raised");

    property p_int_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        dspInterruptAck && !hit(busReq, OFFSET_DSP_INTERRUPT_REQ) |=> !interruptPending;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("Ack did not clear");

    property p_rom_block;
        @(posedge sys_clk) disable iff (!reset_n)
        !ctrl.memoryReadEnable |=> instructionRomRead == '0;
    endproperty
    a_rom_block: assert property (p_rom_block) else $error("ROM read not blocked");

    property p_read_pass;
        @(posedge sys_clk) disable iff (!reset_n)
        ctrl.memoryReadEnable |=> instructionRamRead == $past(instructionRamData);
    endproperty
    a_read_pass: assert property (p_read_pass) else $error("RAM read not passed");

    property p_rst_read;
        @(posedge sys_clk) disable iff (!reset_n)
        busReq.read && busReq.addr == OFFSET_DECRYPT_RESET |=> regReadData == 8'h00;
    endproperty
    a_rst_read: assert property (p_rst_read) else $error("Reset bit read 1");

    property p_drop;
        @(posedge sys_clk) disable iff (!reset_n)
        decryptReset |=> !ramWriteValid;
    endproperty
    a_drop: assert property (p_drop) else $error("Byte kept in reset");

    c_int_ack: cover property (@(posedge sys_clk) disable iff (!reset_n) interruptPending ##1 !interruptPending);
    c_decrypt: cover property (@(posedge sys_clk) disable iff (!reset_n) decryptReset ##[1:4] ramWriteValid);
    c_boot_ram: cover property (@(posedge sys_clk) disable iff (!reset_n) bootFromInstructionRam);
endmodule
`default_nettype wire

/* dbdc_pkg.sv */
`default_nettype none
package dbdc_pkg;

    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 8;

    // Register offsets
    localparam logic [7:0] OFFSET_PIN_TO_DSP_ENABLE = 8'h31;
    localparam logic [7:0] OFFSET_DSP_BOOT_SELECT   = 8'h32;
    localparam logic [7:0] OFFSET_DSP_INTERRUPT_REQ = 8'h33;
    localparam logic [7:0] OFFSET_MEM_READ_DECRYPT  = 8'h34;
    localparam logic [7:0] OFFSET_DECRYPT_RESET     = 8'h35;

    // Field positions
    localparam int POS_PIN2_TO_DSP_ENABLE   = 6;
    localparam int POS_PIN0_TO_DSP_ENABLE   = 4;
    localparam int POS_PIN1_TO_DSP_ENABLE   = 3;
    localparam int POS_BOOT_SOURCE          = 1;
    localparam int POS_COEFFICIENT_SOURCE   = 0;
    localparam int POS_HOST_TO_DSP_INT      = 0;
    localparam int POS_MEMORY_READ_ENABLE   = 3;
    localparam int POS_DECRYPTION_DISABLE   = 2;
    localparam int POS_CRC_SEED_SELECT      = 0;
    localparam int POS_DECRYPTION_RESET     = 0;

    // Reset values
    localparam logic [7:0] RESET_PIN_TO_DSP_ENABLE = 8'h00;
    localparam logic [7:0] RESET_DSP_BOOT_SELECT   = 8'h00;
    localparam logic [7:0] RESET_MEM_READ_DECRYPT  = 8'h00;

    // Writable bit masks
    localparam logic [7:0] MASK_PIN_TO_DSP_ENABLE = 8'hff;
    localparam logic [7:0] MASK_DSP_BOOT_SELECT   = 8'hff;
    localparam logic [7:0] MASK_MEM_READ_DECRYPT  = 8'hff;

    // Seeds for the CRC based decryption
    localparam logic [7:0] CRC_SEED_0 = 8'ha5;
    localparam logic [7:0] CRC_SEED_1 = 8'hb6;
    localparam logic [7:0] CRC_SEED_2 = 8'h94;
    localparam logic [7:0] CRC_SEED_3 = 8'he2;

    // CRC-8 polynomial used by the download scrambler
    localparam logic [7:0] CRC_POLY = 8'h07;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic                  write;
        logic                  read;
    } dbdc_bus_req_type;

    typedef struct packed {
        logic       pin2ToDspEnable;
        logic       pin0ToDspEnable;
        logic       pin1ToDspEnable;
        logic       bootFromRam;
        logic       useDefaultCoefficients;
        logic       memoryReadEnable;
        logic       decryptionDisable;
        logic [1:0] crcSeedSelect;
    } dbdc_ctrl_type;

    function automatic logic [7:0] seed_of(input logic [1:0] sel);
        unique case (sel)
            2'b00: seed_of = CRC_SEED_0;
            2'b01: seed_of = CRC_SEED_1;
            2'b10: seed_of = CRC_SEED_2;
            2'b11: seed_of = CRC_SEED_3;
        endcase
    endfunction

endpackage
`default_nettype wire

/* dbdc_decrypt.sv */
`timescale 1ns/10ps
`default_nettype none
module dbdc_decrypt (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       decryptReset,
    input  wire logic [1:0] crcSeedSelect,
    input  wire logic       decryptionDisable,
    input  wire logic       inValid,
    input  wire logic [7:0] inData,
    output logic            outValid,
    output logic      [7:0] outData,
    output logic      [7:0] crcState
);
    import dbdc_pkg::*;

    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] d);
        logic [7:0] c;
        c = crc ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        crc_step = c;
    endfunction

    // Reset wins over a byte in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            crcState <= CRC_SEED_0;
        end else if (decryptReset) begin
            crcState <= seed_of(crcSeedSelect);
        end else if (inValid && !decryptionDisable) begin
            crcState <= crc_step(crcState, inData);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            outValid <= 1'b0;
            outData  <= 8'h00;
        end else begin
            outValid <= inValid && !decryptReset;
            outData  <= decryptionDisable ? inData : (inData ^ crcState);
        end
    end
endmodule
`default_nettype wire

/* dbdc_mem_gate.sv */
`timescale 1ns/10ps
`default_nettype none
module dbdc_mem_gate #(
    parameter int WIDTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             readEnable,
    input  wire logic [WIDTH-1:0] ramData,
    input  wire logic [WIDTH-1:0] romData,
    input  wire logic [WIDTH-1:0] coefRomData,
    output logic      [WIDTH-1:0] ramGated,
    output logic      [WIDTH-1:0] romGated,
    output logic      [WIDTH-1:0] coefRomGated
);
    import dbdc_pkg::*;

    // Registered so the gated read data leave from flip-flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ramGated     <= '0;
            romGated     <= '0;
            coefRomGated <= '0;
        end else begin
            ramGated     <= readEnable ? ramData : '0;
            romGated     <= readEnable ? romData : '0;
            coefRomGated <= readEnable ? coefRomData : '0;
        end
    end
endmodule
`default_nettype wire

/* dbdc_dsp_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dbdc_dsp_model (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        hostToDspInterrupt,
    input  wire logic [3:0]  ackDelay,
    output logic             dspInterruptAck,
    output logic      [31:0] instructionRamData,
    output logic      [31:0] instructionRomData,
    output logic      [31:0] coefficientRomData
);
    logic [3:0]  waitCount;
    logic        served;
    logic [31:0] pattern;

    // Memory words change every cycle so a stale word cannot pass
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pattern <= 32'h1357_9bdf;
        end else begin
            pattern <= pattern + 32'h9e37_79b9;
        end
    end
    assign instructionRamData = pattern;
    assign instructionRomData = ~pattern;
    assign coefficientRomData = {pattern[15:0], pattern[31:16]};

    // One acknowledge pulse per request, ackDelay cycles after it is seen
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            waitCount       <= 4'h0;
            served          <= 1'b0;
            dspInterruptAck <= 1'b0;
        end else begin
            dspInterruptAck <= 1'b0;
            if (!hostToDspInterrupt) begin
                waitCount <= 4'h0;
                served    <= 1'b0;
            end else if (!served) begin
                if (waitCount == ackDelay) begin
                    dspInterruptAck <= 1'b1;
                    served          <= 1'b1;
                end
                waitCount <= waitCount + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* dbdc_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dbdc_top_test;
    import dbdc_pkg::*;
    localparam int TIMEOUT_CYCLES = 20000;
    logic        sys_clk, reset_n, regWrite, regRead, dspInterruptAck, downloadValid;
    logic [7:0]  regAddr, regWriteData, regReadData, downloadData, ramWriteData;
    logic [2:0]  pins, dspInputPort;
    logic        bootFromInstructionRam, useCoefficientRom, hostToDspInterrupt, ramWriteValid;
    logic [3:0]  ackDelay;
    logic [31:0] ramData, romData, coefData, ramRead, romRead, coefRead;
    int          fails, testsRun, cycleCount;
    logic [7:0]  seeds [4] = '{8'ha5, 8'hb6, 8'h94, 8'he2};

    dbdc_top #(.MEM_WIDTH(32)) u_dbdc_top (.sys_clk(sys_clk), .reset_n(reset_n),
        .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData), .generalPin0(pins[0]),
        .generalPin1(pins[1]), .generalPin2(pins[2]), .dspInputPort(dspInputPort),
        .bootFromInstructionRam(bootFromInstructionRam), .useCoefficientRom(useCoefficientRom),
        .hostToDspInterrupt(hostToDspInterrupt), .dspInterruptAck(dspInterruptAck),
        .downloadValid(downloadValid), .downloadData(downloadData),
        .ramWriteValid(ramWriteValid), .ramWriteData(ramWriteData),
        .instructionRamData(ramData), .instructionRomData(romData),
        .coefficientRomData(coefData), .instructionRamRead(ramRead),
        .instructionRomRead(romRead), .coefficientRomRead(coefRead));

    dbdc_dsp_model u_dbdc_dsp_model (.sys_clk(sys_clk), .reset_n(reset_n),
        .hostToDspInterrupt(hostToDspInterrupt), .ackDelay(ackDelay),
        .dspInterruptAck(dspInterruptAck), .instructionRamData(ramData),
        .instructionRomData(romData), .coefficientRomData(coefData));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycleCount++;
        if (cycleCount == TIMEOUT_CYCLES) begin
            fails++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        testsRun++;
        if (seen !== expected) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        regAddr      <= addr;
        regWriteData <= data;
        regWrite     <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] expected);
        @(posedge sys_clk);
        regAddr <= addr;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check(regReadData, expected);
    endtask

    function automatic logic [7:0] crc_next(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] v;
        v = crc ^ din;
        for (int i = 0; i < 8; i++) begin
            v = v[7] ? ((v << 1) ^ 8'h07) : (v << 1);
        end
        return v;
    endfunction

    task automatic test_reset_values();
        expect_reg(OFFSET_PIN_TO_DSP_ENABLE, 8'h00);
        expect_reg(OFFSET_DSP_BOOT_SELECT, 8'h00);
        expect_reg(OFFSET_DSP_INTERRUPT_REQ, 8'h00);
        expect_reg(OFFSET_MEM_READ_DECRYPT, 8'h00);
        check({dspInputPort, bootFromInstructionRam, hostToDspInterrupt}, 32'h0);
        check(useCoefficientRom, 1'b0);
        reg_write(8'h30, 8'hff);
        expect_reg(8'h30, 8'h00);
    endtask

    task automatic test_pin_gating();
        logic [7:0] enables [5] = '{8'h00, 8'h40, 8'h10, 8'h08, 8'hff};
        foreach (enables[e]) begin
            reg_write(OFFSET_PIN_TO_DSP_ENABLE, enables[e]);
            expect_reg(OFFSET_PIN_TO_DSP_ENABLE, enables[e]);
            for (int p = 0; p < 8; p++) begin
                @(posedge sys_clk);
                pins <= 3'(p);
                repeat (2) @(posedge sys_clk);
                #1;
                check(dspInputPort[2], pins[2] & enables[e][6]);
                check(dspInputPort[0], pins[0] & enables[e][4]);
                check(dspInputPort[1], pins[1] & enables[e][3]);
            end
        end
    endtask

    task automatic test_boot_select();
        for (int v = 0; v < 4; v++) begin
            reg_write(OFFSET_DSP_BOOT_SELECT, 8'ha0 | 8'(v));
            @(posedge sys_clk);
            #1;
            check(bootFromInstructionRam, v[1]);
            check(useCoefficientRom, v[0]);
            expect_reg(OFFSET_DSP_BOOT_SELECT, 8'ha0 | 8'(v));
        end
    endtask

    task automatic test_interrupt(input logic [3:0] delay);
        int n;
        ackDelay <= delay;
        reg_write(OFFSET_DSP_INTERRUPT_REQ, 8'hfe);
        repeat (3) @(posedge sys_clk);
        #1;
        check(hostToDspInterrupt, 1'b0);
        reg_write(OFFSET_DSP_INTERRUPT_REQ, 8'h01);
        expect_reg(OFFSET_DSP_INTERRUPT_REQ, 8'h01);
        check(hostToDspInterrupt, 1'b1);
        n = 0;
        while (hostToDspInterrupt !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check(n, 32'(delay) + 2);
        expect_reg(OFFSET_DSP_INTERRUPT_REQ, 8'h00);
    endtask

    task automatic test_mem_gate();
        logic [31:0] a, b, c;
        for (int en = 0; en < 2; en++) begin
            reg_write(OFFSET_MEM_READ_DECRYPT, 8'(en << 3));
            repeat (3) begin
                @(negedge sys_clk);
                a = en ? ramData : 32'h0;
                b = en ? romData : 32'h0;
                c = en ? coefData : 32'h0;
                @(posedge sys_clk);
                #1;
                check(ramRead, a);
                check(romRead, b);
                check(coefRead, c);
            end
        end
    endtask

    task automatic test_decrypt(input logic [1:0] sel, input logic bypass);
        logic [7:0] crc;
        logic [7:0] prev;
        reg_write(OFFSET_MEM_READ_DECRYPT, {5'h00, bypass, sel});
        reg_write(OFFSET_DECRYPT_RESET, 8'hfe);
        reg_write(OFFSET_DECRYPT_RESET, 8'h01);
        crc = seeds[sel];
        prev = 8'h00;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            downloadValid <= (i < 3);
            downloadData  <= 8'h3c + 8'(i * 8'h51);
            #1;
            if (i > 0) begin
                check(ramWriteValid, 1'b1);
                check(ramWriteData, bypass ? prev : prev ^ crc);
                crc = crc_next(crc, prev);
            end
            prev = downloadData;
        end
        expect_reg(OFFSET_DECRYPT_RESET, 8'h00);
    endtask

    initial begin
        fails = 0;
        testsRun = 0;
        cycleCount = 0;
        reset_n = 1'b0;
        {regWrite, regRead, downloadValid} = 3'b000;
        {regAddr, regWriteData, downloadData} = 24'h0;
        pins = 3'b000;
        ackDelay = 4'h0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        test_reset_values();
        test_pin_gating();
        test_boot_select();
        test_interrupt(4'h0);
        test_interrupt(4'h8);
        test_mem_gate();
        for (int s = 0; s < 4; s++) begin
            test_decrypt(2'(s), 1'b0);
        end
        test_decrypt(2'b10, 1'b1);
        complete_run();
    end
endmodule
`default_nettype wire
